// ==== include/muxed_bus_defs.svh ====
// Constants for the multiplexed bus address capture and module select
`ifndef MUXED_BUS_DEFS_SVH
`define MUXED_BUS_DEFS_SVH
`define AD_WIDTH 8
`define UPPER_WIDTH 8
`define DEC_OUTS 10
`define MOD_COUNT 20
`define MOD_SEL_WIDTH 5
`define BANK_LO 8'h00
`define BANK_HI 8'h01
`define ADDR_RESET 8'h00
`define SEL_IDLE 20'hfffff
`define BCD_LIMIT 4'h9
`define CODE_MSB 3
`define CODE_LSB 0
`define ZONE_MSB 7
`define ZONE_LSB 4
`define ADDR_LIMIT 8'h09
`define BUS_IDLE 8'h00
`endif

// ==== include/muxed_bus_pkg.sv ====
// Types for the multiplexed bus address capture and module select
package muxed_bus_pkg;
  typedef struct packed {
    logic ale;
    logic rd_n;
    logic wr_n;
  } strobes_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ADDR = 2'b01,
    ST_HELD = 2'b10,
    ST_XFER = 2'b11
  } phase_t;

  typedef struct packed {
    logic [7:0] upper;
    logic [7:0] low;
  } full_addr_t;
endpackage

// ==== rtl/bcd_decoder.sv ====
// One-of-ten decoder with active low outputs and an active low enable
`timescale 1ns/1ns
`include "muxed_bus_defs.svh"
module bcd_decoder
(
  input wire logic [3:0] i_code,
  input wire logic i_enable_n,
  output logic [`DEC_OUTS-1:0] o_sel_n
);
  always_comb
  begin
    o_sel_n = {`DEC_OUTS{1'b1}};
    if (!i_enable_n && i_code <= `BCD_LIMIT)
    begin
      o_sel_n[i_code] = 1'b0;
    end
  end

  sel_onehot_a: assert final (i_enable_n || i_code > `BCD_LIMIT ||
    $countones(~o_sel_n) == 1)
    else $error("decoder select not one-hot");
endmodule

// ==== rtl/muxed_bus_module_select.sv ====
// Address capture, decode and bus steering for a multiplexed bus
//
// Notes on behaviour
// - Low eight lines carry address then data; address is held.
// - Address held by D store on falling edge of address strobe; code samples it on the first clock after the fall.
// - Each module answers its own distinct hex address.
// - Decoder asserts exactly one select per address; shared decoders.
// - Decoders are one-of-ten, fed from held address and control.
// - Decoder enables gate strobe, read, write and upper lines.
// - At most one module enabled on the bus at any time.
// - Module enables active low; low connects the module.
// - Disabled module presents high impedance to the bus; here its gated buffer drives zero into the OR merge instead.
// - Always-on circuits reach the bus through a gated buffer.
`timescale 1ns/1ns
`include "muxed_bus_defs.svh"
module muxed_bus_module_select
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire muxed_bus_pkg::strobes_t i_strobes,
  input wire logic [`UPPER_WIDTH-1:0] i_upper_addr,
  input wire logic [`AD_WIDTH-1:0] i_muxed_bus_in,
  input wire logic [`MOD_COUNT*`AD_WIDTH-1:0] i_module_data,
  output logic [`AD_WIDTH-1:0] o_muxed_bus_out,
  output logic o_muxed_bus_oe,
  output logic [`MOD_COUNT-1:0] o_module_en_n,
  output logic [`AD_WIDTH-1:0] o_held_addr,
  output muxed_bus_pkg::phase_t o_phase
);
  // ****************************************
  // Strobe edge detect
  // ****************************************
  logic ale_q;
  logic ale_fall;
  logic [`AD_WIDTH-1:0] addr_q;
  logic [`AD_WIDTH-1:0] addr_d;
  muxed_bus_pkg::phase_t phase_q;
  muxed_bus_pkg::phase_t phase_d;
  logic xfer_active;
  logic [`DEC_OUTS-1:0] sel_lo_n;
  logic [`DEC_OUTS-1:0] sel_hi_n;
  logic en_lo_n;
  logic en_hi_n;
  logic [`MOD_COUNT-1:0] en_n;
  logic [`AD_WIDTH-1:0] bus_q;
  logic oe_q;
  muxed_bus_pkg::full_addr_t target;
  logic [`AD_WIDTH-1:0] gated_data [`MOD_COUNT];
  logic [`AD_WIDTH-1:0] bus_d;

  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
      ale_q <= 1'b0;
    else
      ale_q <= i_strobes.ale;
  end

  assign ale_fall = ale_q && !i_strobes.ale;

  // ****************************************
  // Address capture
  // ****************************************
  // Bus sampled on the first clock after the strobe falls, relying on address still there
  always_comb
  begin
    addr_d = addr_q;
    if (ale_fall)
      addr_d = i_muxed_bus_in;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
      addr_q <= `ADDR_RESET;
    else
      addr_q <= addr_d;
  end

  assign o_held_addr = addr_q;

  // ****************************************
  // Transfer phase tracking
  // ****************************************
  assign xfer_active = !i_strobes.rd_n ^ !i_strobes.wr_n;

  always_comb
  begin
    phase_d = phase_q;
    unique case (phase_q)
      muxed_bus_pkg::ST_IDLE:
        if (i_strobes.ale)
          phase_d = muxed_bus_pkg::ST_ADDR;
      muxed_bus_pkg::ST_ADDR:
        if (ale_fall)
          phase_d = muxed_bus_pkg::ST_HELD;
      muxed_bus_pkg::ST_HELD:
        if (i_strobes.ale)
          phase_d = muxed_bus_pkg::ST_ADDR;
        else if (xfer_active)
          phase_d = muxed_bus_pkg::ST_XFER;
      muxed_bus_pkg::ST_XFER:
        if (i_strobes.ale)
          phase_d = muxed_bus_pkg::ST_ADDR;
        else if (!xfer_active)
          phase_d = muxed_bus_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
      phase_q <= muxed_bus_pkg::ST_IDLE;
    else
      phase_q <= phase_d;
  end

  assign o_phase = phase_q;

  // ****************************************
  // Decode
  // ****************************************
  function automatic logic bank_en_n(
    input logic [`UPPER_WIDTH-1:0] upper,
    input logic [`UPPER_WIDTH-1:0] bank,
    input muxed_bus_pkg::strobes_t s,
    input muxed_bus_pkg::phase_t ph
  );
    // Enable needs strobe low, exactly one of read or write, and bank hit
    bank_en_n = !(!s.ale && (!s.rd_n ^ !s.wr_n) && upper == bank &&
                  ph != muxed_bus_pkg::ST_ADDR);
  endfunction

  // High nibble of a module address must be zero
  function automatic logic zone_miss(input logic [`AD_WIDTH-1:0] a);
    zone_miss = |a[`ZONE_MSB:`ZONE_LSB];
  endfunction

  // Held address joined with the upper lines
  assign target = {i_upper_addr, addr_q};

  assign en_lo_n = bank_en_n(target.upper, `BANK_LO, i_strobes, phase_q);
  assign en_hi_n = bank_en_n(target.upper, `BANK_HI, i_strobes, phase_q);

  // Low nibble picks the module in a bank; module = bank * ten + nibble
  bcd_decoder u_dec_lo
  (
    .i_code(target.low[`CODE_MSB:`CODE_LSB]),
    .i_enable_n(en_lo_n | zone_miss(target.low)),
    .o_sel_n(sel_lo_n)
  );

  bcd_decoder u_dec_hi
  (
    .i_code(target.low[`CODE_MSB:`CODE_LSB]),
    .i_enable_n(en_hi_n | zone_miss(target.low)),
    .o_sel_n(sel_hi_n)
  );

  // Only one bank can match the upper lines, so one select at most
  assign en_n = {sel_hi_n, sel_lo_n};
  assign o_module_en_n = en_n;

  // ****************************************
  // Bus steering
  // ****************************************
  // Each module's data passes a buffer gated by its enable
  generate
    for (genvar g = 0; g < `MOD_COUNT; g++)
    begin : g_buf
      assign gated_data[g] = en_n[g] ? `BUS_IDLE :
        i_module_data[g*`AD_WIDTH +: `AD_WIDTH];
    end
  endgenerate

  // Merge of the buffers; one enable at most, so a plain OR
  always_comb
  begin
    bus_d = `BUS_IDLE;
    for (int m = 0; m < `MOD_COUNT; m++)
    begin
      bus_d = bus_d | gated_data[m];
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
      bus_q <= `BUS_IDLE;
    else
      bus_q <= bus_d;
  end

  // Drive only on a read to a selected module, else float
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
      oe_q <= 1'b0;
    else
      oe_q <= !i_strobes.rd_n && (en_n != `SEL_IDLE);
  end

  assign o_muxed_bus_out = bus_q;
  assign o_muxed_bus_oe = oe_q;

  // ****************************************
  // Checks
  // ****************************************
  sequence s_ale_fall;
    $fell(i_strobes.ale);
  endsequence

  sequence s_read_only;
    !i_strobes.ale && !i_strobes.rd_n && i_strobes.wr_n;
  endsequence

  sequence s_write_only;
    !i_strobes.ale && i_strobes.rd_n && !i_strobes.wr_n;
  endsequence

  addr_capture_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    s_ale_fall |=> o_held_addr == $past(i_muxed_bus_in))
    else $error("address not captured on strobe fall");

  addr_hold_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    !$fell(i_strobes.ale) |=> $stable(o_held_addr))
    else $error("held address changed without strobe");

  one_enable_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    $countones(~o_module_en_n) <= 1)
    else $error("more than one module enabled");

  idle_sel_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_strobes.rd_n && i_strobes.wr_n) |-> o_module_en_n == `SEL_IDLE)
    else $error("select without read or write strobe");

  addr_sel_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    i_strobes.ale |-> o_module_en_n == `SEL_IDLE)
    else $error("select during address phase");

  decode_hit_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    s_read_only ##0 (phase_q != muxed_bus_pkg::ST_ADDR &&
    i_upper_addr == `BANK_LO && o_held_addr <= `ADDR_LIMIT) |->
    !o_module_en_n[o_held_addr[`CODE_MSB:`CODE_LSB]])
    else $error("addressed module not selected");

  float_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (o_module_en_n == `SEL_IDLE) |=> !o_muxed_bus_oe)
    else $error("bus driven with no module enabled");

  read_drive_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (!i_strobes.rd_n && !o_module_en_n[0]) |=>
    o_muxed_bus_oe &&
    o_muxed_bus_out == $past(i_module_data[`AD_WIDTH-1:0]))
    else $error("enabled module data not driven");

  write_float_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    s_write_only |=> !o_muxed_bus_oe)
    else $error("bus driven during a write");

  write_hit_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    s_write_only ##0 (phase_q != muxed_bus_pkg::ST_ADDR &&
    i_upper_addr == `BANK_LO && o_held_addr <= `ADDR_LIMIT) |->
    !o_module_en_n[o_held_addr[`CODE_MSB:`CODE_LSB]])
    else $error("written module not selected");

  hi_bank_hit_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    s_read_only ##0 (phase_q != muxed_bus_pkg::ST_ADDR &&
    i_upper_addr == `BANK_HI && o_held_addr <= `ADDR_LIMIT) |->
    !o_module_en_n[`DEC_OUTS + o_held_addr[`CODE_MSB:`CODE_LSB]])
    else $error("upper bank module not selected");

  range_refuse_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (o_held_addr > `ADDR_LIMIT) |-> o_module_en_n == `SEL_IDLE)
    else $error("select for out of range address");

  bank_miss_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_upper_addr != `BANK_LO && i_upper_addr != `BANK_HI) |->
    o_module_en_n == `SEL_IDLE)
    else $error("select with no bank on upper lines");

  addr_phase_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (phase_q == muxed_bus_pkg::ST_ADDR) |-> o_module_en_n == `SEL_IDLE)
    else $error("select before address captured");

  xfer_end_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (phase_q == muxed_bus_pkg::ST_XFER && !i_strobes.ale &&
    i_strobes.rd_n && i_strobes.wr_n) |=>
    o_phase == muxed_bus_pkg::ST_IDLE)
    else $error("transfer phase did not end");

  addr_start_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (phase_q == muxed_bus_pkg::ST_IDLE && i_strobes.ale) |=>
    o_phase == muxed_bus_pkg::ST_ADDR)
    else $error("address phase not entered");
endmodule

// ==== dv/cpu_bus_model.sv ====
// Processor model that drives address, strobes and the low bus lines
`timescale 1ns/1ns
module cpu_bus_model
(
  input wire logic i_clk,
  output muxed_bus_pkg::strobes_t o_strobes,
  output logic [7:0] o_upper_addr,
  output logic [7:0] o_bus
);
  initial
  begin
    o_strobes = 3'h3;
    o_upper_addr = 8'h00;
    o_bus = 8'h55;
  end
  // ****************
  // Address phase
  // ****************
  task automatic addr_phase(input logic [7:0] a, input logic [7:0] up);
    @(negedge i_clk);
    o_strobes.ale = 1'b1;
    o_bus = a;
    o_upper_addr = up;
    @(negedge i_clk);
    o_strobes.ale = 1'b0;
    @(negedge i_clk);
    o_bus = ~a;
  endtask
  task automatic strobe(input logic rd, input logic wr);
    @(negedge i_clk);
    o_strobes.rd_n = rd;
    o_strobes.wr_n = wr;
  endtask
endmodule

// ==== dv/tb_muxed_bus_module_select.sv ====
// Self-checking bench for multiplexed bus capture and module select
`timescale 1ns/1ns
module tb_muxed_bus_module_select;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  muxed_bus_pkg::strobes_t strobes;
  logic [7:0] upper;
  logic [7:0] bus_in;
  logic [7:0] bus_out;
  logic [7:0] held;
  logic [159:0] mdata;
  logic oe;
  logic [19:0] en_n;
  muxed_bus_pkg::phase_t phase;
  int bad_count = 0;
  int checks = 0;
  int cycles = 0;
  initial
  begin
    forever #20 i_clk = ~i_clk;
  end
  cpu_bus_model cpu
  (
    .i_clk(i_clk),
    .o_strobes(strobes),
    .o_upper_addr(upper),
    .o_bus(bus_in)
  );
  muxed_bus_module_select uut
  (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_strobes(strobes),
    .i_upper_addr(upper),
    .i_muxed_bus_in(bus_in),
    .i_module_data(mdata),
    .o_muxed_bus_out(bus_out),
    .o_muxed_bus_oe(oe),
    .o_module_en_n(en_n),
    .o_held_addr(held),
    .o_phase(phase)
  );
  // ****************
  // Shared tasks
  // ****************
  task automatic chk(input string nm, input logic [19:0] e,
    input logic [19:0] g);
    checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic xfer(input logic [7:0] a, input logic [7:0] up,
    input logic rd, input logic wr, input logic [19:0] e_en,
    input logic e_oe, input logic [7:0] e_out);
    logic [1:0] p_run;
    logic [1:0] p_end;
    p_run = (rd ^ wr) ? muxed_bus_pkg::ST_XFER : muxed_bus_pkg::ST_HELD;
    p_end = (rd ^ wr) ? muxed_bus_pkg::ST_IDLE : muxed_bus_pkg::ST_HELD;
    cpu.addr_phase(a, up);
    cpu.strobe(rd, wr);
    repeat (2) @(negedge i_clk);
    chk("held", {12'h0, a}, {12'h0, held});
    chk("phase", {18'h0, p_run}, {18'h0, phase});
    chk("en_n", e_en, en_n);
    chk("oe", {19'h0, e_oe}, {19'h0, oe});
    chk("out", {12'h0, e_out}, {12'h0, bus_out});
    cpu.strobe(1'b1, 1'b1);
    repeat (2) @(negedge i_clk);
    chk("idle", 20'hfffff, en_n);
    chk("oe_off", 20'h0, {19'h0, oe});
    chk("phase_end", {18'h0, p_end}, {18'h0, phase});
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic read_all;
    for (int m = 0; m < 20; m++)
      xfer(8'(m % 10), 8'(m / 10), 1'b0, 1'b1, ~(20'h1 << m), 1'b1,
        8'ha0 ^ 8'(m));
  endtask
  task automatic write_pair;
    xfer(8'h09, 8'h00, 1'b1, 1'b0, ~(20'h1 << 9), 1'b0, 8'ha9);
    xfer(8'h00, 8'h01, 1'b1, 1'b0, ~(20'h1 << 10), 1'b0, 8'haa);
  endtask
  task automatic refused;
    xfer(8'h0a, 8'h00, 1'b0, 1'b1, 20'hfffff, 1'b0, 8'h00);
    xfer(8'h13, 8'h00, 1'b0, 1'b1, 20'hfffff, 1'b0, 8'h00);
    xfer(8'h02, 8'h02, 1'b0, 1'b1, 20'hfffff, 1'b0, 8'h00);
    xfer(8'h05, 8'h00, 1'b0, 1'b0, 20'hfffff, 1'b0, 8'h00);
  endtask
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      bad_count++;
      report_and_stop();
    end
  end
  initial
  begin
    for (int m = 0; m < 20; m++)
      mdata[8*m +: 8] = 8'ha0 ^ 8'(m);
    repeat (2) @(negedge i_clk);
    i_reset_n = 1'b1;
    read_all();
    write_pair();
    refused();
    report_and_stop();
  end
endmodule
